// ---- rsts_pkg.sv ----
// Package for the row scan token shifter: stage count, split point and pin levels.
// Assumes every file that needs these writes rsts_pkg::name.
package rsts_pkg;
  localparam int          NUM_STAGES   = 40;
  localparam int          SPLIT_STAGE  = 20;
  localparam logic        DIR_FORWARD  = 1'b1;
  localparam logic        POL_HIGH     = 1'b1;
  localparam logic        OE_N_OFF     = 1'b1;
  localparam logic [39:0] STAGES_CLEAR = 40'h00_0000_0000;
endpackage

// ---- rsts_shifter.sv ----
// Row scan token shifter: 40 stages, bidirectional token ports, tri-state row drives.
// Assumes the controller supplies clean pin levels; all pin inputs except nrst_i are synchronised here.
`timescale 1ns/10ps
module rsts_shifter #(
  parameter int NUM_STAGES = rsts_pkg::NUM_STAGES
) (
  input  wire logic                  clk_sys_i,
  input  wire logic                  nrst_i,
  input  wire logic                  token_port_a_i,
  input  wire logic                  token_port_b_i,
  input  wire logic                  dir_select_i,
  input  wire logic                  split_select_i,
  input  wire logic                  drive_polarity_select_i,
  input  wire logic                  out_enable_n_i,
  output logic                       token_port_a_o,
  output logic                       token_port_a_oe_o,
  output logic                       token_port_b_o,
  output logic                       token_port_b_oe_o,
  output logic [NUM_STAGES-1:0]      row_drive_output_o,
  output logic [NUM_STAGES-1:0]      row_drive_output_oe_o
);

  // The split point and the clear pattern are sized for the package stage count.
  if (NUM_STAGES != rsts_pkg::NUM_STAGES) begin : g_bad_stage_count
    $error("Stage count must equal the package stage count.");
  end

  localparam int HALF        = rsts_pkg::SPLIT_STAGE;
  // Each pin spends two clocks in its synchroniser, so the token out is taken that many
  // stages early; a chained device then lights its first row right after our last one.
  localparam int SYNC_STAGES = 2;
  localparam int OUT_TAP     = NUM_STAGES - 1 - SYNC_STAGES;

  logic                  sync_a;
  logic                  sync_b;
  logic                  sync_dir;
  logic                  sync_split;
  logic                  sync_pol;
  logic                  sync_oe_n;
  logic                  a_q;
  logic                  b_q;
  logic                  dir_q;
  logic                  split_q;
  logic                  pol_q;
  logic                  oe_n_q;
  logic                  token_in;
  logic [NUM_STAGES-1:0] stages;
  logic                  token_fall;
  logic [NUM_STAGES-1:0] row_map;

  // Two flip-flop synchronisers; only the second stage is read.
  // The selects are static levels that the controller changes only between scans, so each
  // bit is synchronised on its own and no word needs a handshake.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      dir_q <= 1'b0;
      split_q <= 1'b0;
      pol_q <= 1'b0;
      oe_n_q <= rsts_pkg::OE_N_OFF;
      sync_dir <= 1'b0;
      sync_split <= 1'b0;
      sync_pol <= 1'b0;
      sync_oe_n <= rsts_pkg::OE_N_OFF;
    end else begin
      sync_a <= token_port_a_i;
      sync_b <= token_port_b_i;
      sync_dir <= dir_select_i;
      sync_split <= split_select_i;
      sync_pol <= drive_polarity_select_i;
      sync_oe_n <= out_enable_n_i;
      a_q <= sync_a;
      b_q <= sync_b;
      dir_q <= sync_dir;
      split_q <= sync_split;
      pol_q <= sync_pol;
      oe_n_q <= sync_oe_n;
    end
  end

  // Only the port facing away from the output direction is listened to.
  assign token_in = (dir_q == rsts_pkg::DIR_FORWARD) ? a_q : b_q;

  // Reset is only for simulation cleanliness; the token clear is the functional reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stages <= rsts_pkg::STAGES_CLEAR;
    end else if (token_in) begin
      stages <= {{(NUM_STAGES-1){1'b0}}, 1'b1};
    end else begin
      stages <= {stages[NUM_STAGES-2:0], 1'b0};
    end
  end

  // Stage k (0 based) becomes a row number depending on direction and split.
  function automatic int row_of(input int k, input logic dir, input logic split);
    int r;
    r = 0;
    if (!split) begin
      r = dir ? k : NUM_STAGES-1-k;
    end else if (dir) begin
      r = (k < HALF) ? k+HALF : k-HALF;
    end else begin
      r = (k < HALF) ? HALF-1-k : NUM_STAGES-1-(k-HALF);
    end
    return r;
  endfunction

  always_comb begin
    row_map = '0;
    for (int k = 0; k < NUM_STAGES; k++) begin
      row_map[row_of(k, dir_q, split_q)] = stages[k];
    end
  end

  // Registered rows; only the single token row is ever enabled.
  // Registering costs one clock between a stage and its row but keeps every enable glitch free.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      row_drive_output_o <= '0;
      row_drive_output_oe_o <= '0;
    end else if (oe_n_q == rsts_pkg::OE_N_OFF) begin
      row_drive_output_o <= '0;
      row_drive_output_oe_o <= '0;
    end else begin
      row_drive_output_o <= (pol_q == rsts_pkg::POL_HIGH) ? row_map : '0;
      row_drive_output_oe_o <= row_map;
    end
  end

  // The tap stage is caught on the rising edge by the stage register and handed out on the
  // falling edge, so a chained input sees it stable around its own rising edge.
  always_ff @(negedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      token_fall <= 1'b0;
    end else begin
      token_fall <= stages[OUT_TAP];
    end
  end

  // Buffered output on the far port; the input port is left undriven.
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      token_port_a_oe_o <= 1'b0;
      token_port_b_oe_o <= 1'b0;
    end else begin
      token_port_a_oe_o <= (dir_q != rsts_pkg::DIR_FORWARD);
      token_port_b_oe_o <= (dir_q == rsts_pkg::DIR_FORWARD);
    end
  end

  assign token_port_a_o = token_fall;
  assign token_port_b_o = token_fall;

  a_one_row_driven: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $onehot0(row_drive_output_oe_o)) else $error("More than one row driven.");

  a_oe_off_hiz: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    oe_n_q |=> (row_drive_output_oe_o == '0)) else $error("Rows driven while disabled.");

  a_clear_on_token: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    token_in |=> (stages == 40'h00_0000_0001)) else $error("Injection did not clear.");

  sequence s_walk;
    token_in ##1 (!token_in)[*8];
  endsequence

  a_token_walks: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    s_walk |=> stages[8]) else $error("Token did not advance.");

  a_zero_hiz: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !oe_n_q && (row_map == '0) |=> (row_drive_output_oe_o == '0))
    else $error("Empty row driven.");

  a_pol_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !pol_q |=> (row_drive_output_o == '0)) else $error("Low polarity drove high.");

  a_delay_out: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    token_port_b_o == stages[OUT_TAP]) else $error("Token output lost.");

  a_port_dir: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    dir_q |=> (token_port_b_oe_o && !token_port_a_oe_o)) else $error("Wrong output port.");

  a_port_dir_low: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !dir_q |=> (token_port_a_oe_o && !token_port_b_oe_o)) else $error("Wrong output port.");

  a_pol_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !oe_n_q && pol_q |=> (row_drive_output_o == row_drive_output_oe_o))
    else $error("High polarity row not driven high.");

  a_single_token: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $onehot0(stages)) else $error("More than one token held.");

  // Rows in linear forward order are the stages themselves, one clock later.
  a_row_linear: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !oe_n_q && dir_q && !split_q |=> (row_drive_output_oe_o == $past(stages)))
    else $error("Linear row order broken.");

  a_row_split: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    !oe_n_q && dir_q && split_q |=>
      (row_drive_output_oe_o == {$past(stages[HALF-1:0]), $past(stages[NUM_STAGES-1:HALF])}))
    else $error("Split row order broken.");

  // Seen at a falling edge, the token out shows the tap as it stood one falling edge before.
  a_out_on_fall: assert property (@(negedge clk_sys_i) disable iff (!nrst_i)
    token_port_a_o == $past(stages[OUT_TAP])) else $error("Token out not on falling edge.");

endmodule

// ---- rsts_ctrl_model.sv ----
// Timing controller model: puts the token on the input port chosen by direction.
// Assumes the bench pulses inject_i for one clock, changed at a falling edge.
`timescale 1ns/10ps
module rsts_ctrl_model (
  input  wire logic dir_select_i,
  input  wire logic inject_i,
  input  wire logic pin_a_drv_i,
  input  wire logic pin_a_oe_i,
  input  wire logic pin_b_drv_i,
  input  wire logic pin_b_oe_i,
  output logic      token_port_a_o,
  output logic      token_port_b_o
);
  // The controller drives whichever port the device leaves undriven and holds it low between tokens.
  assign token_port_a_o = pin_a_oe_i ? pin_a_drv_i : (dir_select_i & inject_i);
  assign token_port_b_o = pin_b_oe_i ? pin_b_drv_i : (!dir_select_i & inject_i);
endmodule

// ---- testbench.sv ----
// Self-checking bench for the row scan token shifter with a controller model.
// Assumes the token out is seen NUM_STAGES posedges after the edge that first samples the input.
`timescale 1ns/10ps
module testbench;
  logic        clk_sys_i = 0, nrst_i = 0, dir = 1, split = 0, drive_polarity_select = 1, oe_n = 0, inject = 0;
  logic        pa_i, pb_i, pa_o, pa_oe, pb_o, pb_oe, tok, tok_d;
  logic [39:0] row, row_oe;
  logic [6:0]  q[$];
  logic [6:0]  e;
  logic [31:0] seed = 32'h0001_34b6;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  rsts_shifter i_rsts_shifter (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .token_port_a_i(pa_i),
    .token_port_b_i(pb_i), .dir_select_i(dir), .split_select_i(split),
    .drive_polarity_select_i(drive_polarity_select), .out_enable_n_i(oe_n), .token_port_a_o(pa_o),
    .token_port_a_oe_o(pa_oe), .token_port_b_o(pb_o), .token_port_b_oe_o(pb_oe),
    .row_drive_output_o(row), .row_drive_output_oe_o(row_oe));
  rsts_ctrl_model i_rsts_ctrl_model (.dir_select_i(dir), .inject_i(inject),
    .pin_a_drv_i(pa_o), .pin_a_oe_i(pa_oe), .pin_b_drv_i(pb_o), .pin_b_oe_i(pb_oe),
    .token_port_a_o(pa_i), .token_port_b_o(pb_i));
  assign tok = dir ? pb_o : pa_o;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic int row_of(int k, logic d, logic s);
    if (!s) return d ? k : 39 - k;
    if (d) return k < 20 ? k + 20 : k - 20;
    return k < 20 ? 19 - k : 59 - k;
  endfunction
  task automatic chk(logic [39:0] seen, logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Rows below 40 cut the scan short so the next call re-injects after exactly that many rows.
  task automatic scan(logic d, logic s, logic oen, int rows);
    dir = d;
    split = s;
    oe_n = oen;
    seed = xs(seed);
    drive_polarity_select = seed[0];
    repeat (4) @(negedge clk_sys_i);
    inject = 1;
    if (!oen) for (int k = 0; k < rows; k++) q.push_back({drive_polarity_select, 6'(row_of(k, d, s))});
    @(negedge clk_sys_i);
    inject = 0;
    repeat (rows < 40 ? rows - 5 : 46) @(negedge clk_sys_i);
  endtask
  always @(negedge clk_sys_i) begin
    if (nrst_i && |row_oe) begin
      if (q.size() == 0) chk(row_oe, '0);
      else begin
        e = q.pop_front();
        chk(row_oe, 40'h00_0000_0001 << e[5:0]);
        chk(row, e[6] ? 40'h00_0000_0001 << e[5:0] : 40'h00_0000_0000);
      end
    end
  end
  always @(posedge clk_sys_i) begin
    cyc <= inject ? 1 : cyc + 1;
    tok_d <= tok;
    if (nrst_i && tok && !tok_d) begin
      chk(40'(cyc), 40'(rsts_pkg::NUM_STAGES));
      chk(40'({pa_oe, pb_oe}), dir ? 40'h1 : 40'h2);
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    nrst_i = 1;
    for (int m = 0; m < 4; m++) scan(m[0], m[1], 0, 40);
    scan(1, 1, 1, 40);
    scan(0, 1, 0, 12);
    scan(0, 1, 0, 40);
    repeat (3) begin
      seed = xs(seed);
      scan(seed[1], seed[2], 0, 40);
    end
    repeat (4) @(negedge clk_sys_i);
    chk(40'(q.size()), '0);
    final_report();
  end
  // The full run needs about 480 clocks; the 1200-clock limit leaves ample margin.
  initial begin
    #6000;
    fail_count++;
    final_report();
  end
endmodule
